/* File: src/event_recorder.sv */
// time-tagged circular event recorder for a protection relay
// Functional notes
// RQ1: store up to 200 time-tagged entries in retentive memory.
// RQ2: when full, a new entry overwrites the oldest one.
// RQ3: each entry carries a millisecond time tag from the clock.
// RQ4: a change of binary inputs since last pass logs one event.
// RQ5: a change of relay contacts since last pass logs one event.
// RQ6: each alarm change is logged as its own entry.
// RQ7: an alarm entry carries its bit number 0 to 31.
// RQ8: aux supply fail is bit 0, transformer supply fail is bit 1.
// RQ9: an alarm entry carries an on/off flag.
// RQ10: a protection trip logs element number and event value.
// RQ11: stored entries are readable by the remote reader port.
// RQ12: write pointer advances per entry; count saturates at capacity.
`timescale 1ns/100ps
`default_nettype none
module event_recorder
(
    input  wire logic                                    CLK,
    input  wire logic                                    RESET,
    input  wire logic                                    PASS_DONE,
    input  wire logic [event_rec_pkg::IN_W-1:0]          BINARY_IN,
    input  wire logic [event_rec_pkg::RELAY_W-1:0]       RELAY_STATE,
    input  wire logic [event_rec_pkg::ALARM_W-1:0]       ALARM_STATE,
    input  wire logic                                    TRIP_VALID,
    input  wire logic [event_rec_pkg::ELEM_W-1:0]        TRIP_ELEMENT,
    input  wire logic [event_rec_pkg::VALUE_W-1:0]       TRIP_VALUE,
    input  wire logic                                    TIME_LOAD,
    input  wire logic [event_rec_pkg::STAMP_W-1:0]       TIME_VALUE,
    input  wire logic                                    READ_REQ,
    input  wire logic [event_rec_pkg::PTR_W-1:0]         READ_AGE,
    output var  logic                                    READ_VALID,
    output var  logic [event_rec_pkg::ENTRY_W-1:0]       READ_DATA,
    output var  logic [event_rec_pkg::PTR_W-1:0]         WRITE_PTR,
    output var  logic [event_rec_pkg::COUNT_W-1:0]       ENTRY_COUNT,
    output var  logic                                    BUSY
);
    event_rec_pkg::state_e state;
    event_rec_pkg::state_e next_state;

    logic [event_rec_pkg::IN_W-1:0]    last_in;
    logic [event_rec_pkg::RELAY_W-1:0] last_relay;
    logic [event_rec_pkg::ALARM_W-1:0] last_alarm;
    logic [event_rec_pkg::IN_W-1:0]    snap_in;
    logic [event_rec_pkg::RELAY_W-1:0] snap_relay;
    logic [event_rec_pkg::ALARM_W-1:0] snap_alarm;
    logic                              in_pend;
    logic                              relay_pend;
    logic                              trip_pend;
    logic [event_rec_pkg::ELEM_W-1:0]  trip_elem;
    logic [event_rec_pkg::VALUE_W-1:0] trip_val;
    logic [event_rec_pkg::ALARM_W-1:0] alarm_pend;
    logic [event_rec_pkg::ENTRY_W-1:0] wr_data;
    logic                              rd_pend;
    logic [event_rec_pkg::ENTRY_W-1:0] rd_data;
    logic [event_rec_pkg::STAMP_W-1:0] now_ms;

    // lowest pending alarm bit
    logic [event_rec_pkg::ELEM_W-1:0]  alarm_idx;
    logic                              alarm_any;
    always_comb
    begin
        alarm_idx = '0;
        alarm_any = 1'b0;
        for (int i = event_rec_pkg::ALARM_W - 1; i >= 0; i--)
        begin
            if (alarm_pend[i])
            begin
                alarm_idx = event_rec_pkg::ELEM_W'(i);
                alarm_any = 1'b1;
            end
        end
    end

    wire in_change    = PASS_DONE && (BINARY_IN != last_in);       // RQ4
    wire relay_change = PASS_DONE && (RELAY_STATE != last_relay);  // RQ5
    wire [event_rec_pkg::ALARM_W-1:0] alarm_change =
        PASS_DONE ? (ALARM_STATE ^ last_alarm) : '0;                // RQ6
    wire pass_take    = (state == event_rec_pkg::ST_SCAN) && PASS_DONE;
    wire sel_in       = in_pend;
    wire sel_relay    = !in_pend && relay_pend;
    wire sel_trip     = !in_pend && !relay_pend && trip_pend;
    wire sel_alarm    = !in_pend && !relay_pend && !trip_pend && alarm_any;
    wire do_write     = (state == event_rec_pkg::ST_WRITE);
    wire alarm_on     = snap_alarm[alarm_idx];                      // RQ9
    wire full         = (ENTRY_COUNT == event_rec_pkg::COUNT_FULL);
    wire [event_rec_pkg::PTR_W-1:0] ptr_inc =
        (WRITE_PTR == event_rec_pkg::LAST_SLOT) ? event_rec_pkg::PTR_RESET
                                                : WRITE_PTR + 1'b1;
    // read slot counted back from the newest entry
    wire [event_rec_pkg::PTR_W:0] back =
        {1'b0, WRITE_PTR} - {1'b0, READ_AGE} - 9'h001;
    wire [event_rec_pkg::PTR_W-1:0] rd_addr = back[event_rec_pkg::PTR_W]
        ? event_rec_pkg::PTR_W'(back + 9'h0C8)
        : back[event_rec_pkg::PTR_W-1:0];

    always_comb
    begin
        wr_data = '0;
        if (sel_in)
            wr_data = {event_rec_pkg::KIND_INPUT,
                       (event_rec_pkg::DATA_W)'(snap_in), now_ms};    // RQ4
        else if (sel_relay)
            wr_data = {event_rec_pkg::KIND_RELAY,
                       (event_rec_pkg::DATA_W)'(snap_relay), now_ms}; // RQ5
        else if (sel_trip)
            wr_data = {event_rec_pkg::KIND_TRIP, 11'h000, trip_elem,
                       trip_val, now_ms};                             // RQ10
        else
            wr_data = {event_rec_pkg::KIND_ALARM, 26'h0000000, alarm_on,
                       alarm_idx, now_ms};                            // RQ7
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            event_rec_pkg::ST_SCAN:
                if (in_pend || relay_pend || trip_pend || alarm_any)
                    next_state = event_rec_pkg::ST_ALARM;
            event_rec_pkg::ST_ALARM:
                next_state = event_rec_pkg::ST_WRITE;
            event_rec_pkg::ST_WRITE:
                next_state = event_rec_pkg::ST_SCAN;
            default:
                next_state = event_rec_pkg::ST_SCAN;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            state <= event_rec_pkg::ST_SCAN;
        else
            state <= next_state;
    end

    // previous-pass snapshots taken only while idle
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            last_in    <= '0;
            last_relay <= '0;
            last_alarm <= '0;
        end
        else if (pass_take)
        begin
            last_in    <= BINARY_IN;
            last_relay <= RELAY_STATE;
            last_alarm <= ALARM_STATE;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            in_pend    <= 1'b0;
            relay_pend <= 1'b0;
            alarm_pend <= '0;
            snap_in    <= '0;
            snap_relay <= '0;
            snap_alarm <= '0;
        end
        else if (pass_take)
        begin
            in_pend    <= in_pend | in_change;
            relay_pend <= relay_pend | relay_change;
            alarm_pend <= alarm_pend | alarm_change;
            snap_in    <= BINARY_IN;
            snap_relay <= RELAY_STATE;
            snap_alarm <= ALARM_STATE;
        end
        else if (do_write)
        begin
            if (sel_in)
                in_pend <= 1'b0;
            else if (sel_relay)
                relay_pend <= 1'b0;
            else if (sel_alarm)
                alarm_pend[alarm_idx] <= 1'b0;                    // RQ6
        end
    end

    // trip capture; a new trip wins over the clear of the old one
    always_ff @(posedge CLK)
    begin
        if (RESET)
            trip_pend <= 1'b0;
        else if (TRIP_VALID)
            trip_pend <= 1'b1;                                    // RQ10
        else if (do_write && sel_trip)
            trip_pend <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            trip_elem <= '0;
            trip_val  <= '0;
        end
        else if (TRIP_VALID)
        begin
            trip_elem <= TRIP_ELEMENT;
            trip_val  <= TRIP_VALUE;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            WRITE_PTR   <= event_rec_pkg::PTR_RESET;
            ENTRY_COUNT <= event_rec_pkg::COUNT_RESET;
        end
        else if (do_write)
        begin
            WRITE_PTR <= ptr_inc;                                 // RQ2
            if (!full)
                ENTRY_COUNT <= ENTRY_COUNT + 1'b1;                // RQ12
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rd_pend    <= 1'b0;
            READ_VALID <= 1'b0;
            READ_DATA  <= '0;
            BUSY       <= 1'b0;
        end
        else
        begin
            rd_pend    <= READ_REQ;
            READ_VALID <= rd_pend;                                // RQ11
            if (rd_pend)
                READ_DATA <= rd_data;
            BUSY <= (next_state != event_rec_pkg::ST_SCAN);
        end
    end

    event_store u_store
    (
        .clk     (CLK),
        .wr_en   (do_write),                                      // RQ1
        .wr_addr (WRITE_PTR),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    ms_clock u_clock
    (
        .clk        (CLK),
        .reset      (RESET),
        .load       (TIME_LOAD),
        .load_value (TIME_VALUE),
        .ms_count   (now_ms)                                      // RQ3
    );

    // the two supply alarms sit at fixed bit positions of the alarm word
    wire aux_supply_fail_alarm =
        snap_alarm[event_rec_pkg::AUX_SUPPLY_BIT];                // RQ8
    wire current_transformer_supply_fail_alarm =
        snap_alarm[event_rec_pkg::CT_SUPPLY_BIT];                 // RQ8
    wire alarm_flag = wr_data[event_rec_pkg::STAMP_W + event_rec_pkg::ELEM_W];

    AST_COUNT_SAT: assert property (@(posedge CLK) disable iff (RESET) // RQ12
        ENTRY_COUNT <= event_rec_pkg::COUNT_FULL)
        else $error("entry count above capacity");
    AST_PTR_RANGE: assert property (@(posedge CLK) disable iff (RESET) // RQ1
        WRITE_PTR <= event_rec_pkg::LAST_SLOT)
        else $error("write pointer out of range");
    AST_PTR_WRAP: assert property (@(posedge CLK) disable iff (RESET) // RQ2
        do_write && WRITE_PTR == event_rec_pkg::LAST_SLOT |=>
        WRITE_PTR == event_rec_pkg::PTR_RESET)
        else $error("pointer did not wrap");
    AST_PTR_STEP: assert property (@(posedge CLK) disable iff (RESET) // RQ12
        do_write && WRITE_PTR != event_rec_pkg::LAST_SLOT |=>
        WRITE_PTR == $past(WRITE_PTR) + 1'b1)
        else $error("pointer did not advance");
    AST_IN_EVENT: assert property (@(posedge CLK) disable iff (RESET) // RQ4
        pass_take && in_change |=> in_pend)
        else $error("input change not pending");
    AST_RELAY_EVENT: assert property (@(posedge CLK) disable iff (RESET) // RQ5
        pass_take && relay_change |=> relay_pend)
        else $error("relay change not pending");
    AST_ALARM_ONE: assert property (@(posedge CLK) disable iff (RESET) // RQ6
        do_write && sel_alarm |=> !alarm_pend[$past(alarm_idx)])
        else $error("alarm entry not retired");
    AST_TRIP_LOG: assert property (@(posedge CLK) disable iff (RESET) // RQ10
        TRIP_VALID |=> trip_pend)
        else $error("trip not pending");
    AST_READ_LAT: assert property (@(posedge CLK) disable iff (RESET) // RQ11
        READ_REQ |-> ##2 READ_VALID)
        else $error("read answer late");
    AST_ALARM_BITS: assert property (@(posedge CLK) disable iff (RESET) // RQ8
        do_write && sel_alarm &&
        alarm_idx == event_rec_pkg::ELEM_W'(event_rec_pkg::AUX_SUPPLY_BIT)
        |-> alarm_flag == aux_supply_fail_alarm)
        else $error("aux supply alarm entry has wrong flag");
    AST_CT_BIT: assert property (@(posedge CLK) disable iff (RESET) // RQ8
        do_write && sel_alarm &&
        alarm_idx == event_rec_pkg::ELEM_W'(event_rec_pkg::CT_SUPPLY_BIT)
        |-> alarm_flag == current_transformer_supply_fail_alarm)
        else $error("transformer supply alarm entry has wrong flag");

    COV_FULL: cover property (@(posedge CLK) full && do_write);
    COV_ALARM: cover property (@(posedge CLK) do_write && sel_alarm);
    COV_TRIP: cover property (@(posedge CLK) do_write && sel_trip);
    COV_READ: cover property (@(posedge CLK) READ_VALID);
endmodule : event_recorder
`default_nettype wire

/* File: src/event_rec_pkg.sv */
// constants and types shared by the event recorder files
package event_rec_pkg;
    localparam int unsigned LOG_DEPTH      = 200;
    localparam int unsigned PTR_W          = 8;
    localparam int unsigned COUNT_W        = 8;
    localparam int unsigned IN_W           = 8;
    localparam int unsigned RELAY_W        = 8;
    localparam int unsigned ALARM_W        = 32;
    localparam int unsigned ELEM_W         = 5;
    localparam int unsigned VALUE_W        = 16;
    localparam int unsigned STAMP_W        = 48;
    localparam int unsigned KIND_W         = 2;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned ENTRY_W        = KIND_W + DATA_W + STAMP_W;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned TICK_US        = 1000;
    localparam int unsigned TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int unsigned TICK_W         = 18;
    localparam int unsigned AUX_SUPPLY_BIT = 0;
    localparam int unsigned CT_SUPPLY_BIT  = 1;
    localparam logic [PTR_W-1:0]   PTR_RESET   = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [PTR_W-1:0]   LAST_SLOT   = 8'hC7;
    localparam logic [COUNT_W-1:0] COUNT_FULL  = 8'hC8;

    typedef enum logic [1:0]
    {
        KIND_INPUT = 2'h0,
        KIND_RELAY = 2'h1,
        KIND_ALARM = 2'h3,
        KIND_TRIP  = 2'h2
    } kind_e;

    typedef enum logic [1:0]
    {
        ST_SCAN  = 2'h0,
        ST_ALARM = 2'h1,
        ST_WRITE = 2'h3
    } state_e;
endpackage : event_rec_pkg

/* File: src/event_store.sv */
// event storage memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module event_store
(
    input  wire logic                                    clk,
    input  wire logic                                    wr_en,
    input  wire logic [event_rec_pkg::PTR_W-1:0]         wr_addr,
    input  wire logic [event_rec_pkg::ENTRY_W-1:0]       wr_data,
    input  wire logic [event_rec_pkg::PTR_W-1:0]         rd_addr,
    output var  logic [event_rec_pkg::ENTRY_W-1:0]       rd_data
);
    // retention across power loss is the backing technology's job
    logic [event_rec_pkg::ENTRY_W-1:0] mem [event_rec_pkg::LOG_DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule : event_store
`default_nettype wire

/* File: src/ms_clock.sv */
// real-time clock counting milliseconds
`timescale 1ns/100ps
`default_nettype none
module ms_clock
(
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire logic                                load,
    input  wire logic [event_rec_pkg::STAMP_W-1:0]   load_value,
    output var  logic [event_rec_pkg::STAMP_W-1:0]   ms_count
);
    localparam logic [event_rec_pkg::TICK_W-1:0] TICK_LAST =
        event_rec_pkg::TICK_W'(event_rec_pkg::TICK_CYCLES - 1);

    logic [event_rec_pkg::TICK_W-1:0] tick;
    wire  tick_done = (tick == TICK_LAST);

    always_ff @(posedge clk)
    begin
        if (reset || load || tick_done)
            tick <= '0;
        else
            tick <= tick + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ms_count <= '0;
        else if (load)
            ms_count <= load_value;
        else if (tick_done)
            ms_count <= ms_count + 1'b1; // RQ3
    end
endmodule : ms_clock
`default_nettype wire

/* File: bench/remote_reader.sv */
// remote reader model that fetches stored entries by age
`timescale 1ns/100ps
`default_nettype none
module remote_reader
(
    input  wire logic                              clk,
    output var  logic                              read_req,
    output var  logic [event_rec_pkg::PTR_W-1:0]   read_age,
    input  wire logic                              read_valid,
    input  wire logic [event_rec_pkg::ENTRY_W-1:0] read_data
);
    initial
    begin
        read_req = 1'b0;
        read_age = 8'h00;
    end

    // one request cycle, then a bounded wait for the answer
    task automatic fetch(input logic [7:0] age,
                         output logic [event_rec_pkg::ENTRY_W-1:0] data,
                         output logic got);
        got = 1'b0;
        data = '0;
        @(posedge clk);
        read_req <= 1'b1;
        read_age <= age;
        @(posedge clk);
        read_req <= 1'b0;
        // age is no longer qualified, so it must not hold its value
        read_age <= ~age;
        for (int i = 0; i < 8 && !got; i++)
        begin
            @(posedge clk);
            #1;
            if (read_valid === 1'b1)
            begin
                data = read_data;
                got = 1'b1;
            end
        end
    endtask : fetch
endmodule : remote_reader
`default_nettype wire

/* File: bench/test_protection_event_recorder.sv */
// self-checking bench for the event recorder
`timescale 1ns/100ps
`default_nettype none
module test_protection_event_recorder;
    typedef logic [event_rec_pkg::ENTRY_W-1:0] entry_t;
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        PASS_DONE = 1'b0;
    logic [7:0]  BINARY_IN = 8'h00;
    logic [7:0]  RELAY_STATE = 8'h00;
    logic [31:0] ALARM_STATE = 32'h0000_0000;
    logic        TRIP_VALID = 1'b0;
    logic [4:0]  TRIP_ELEMENT = 5'h00;
    logic [15:0] TRIP_VALUE = 16'h0000;
    logic        TIME_LOAD = 1'b0;
    logic [47:0] TIME_VALUE = 48'h0;
    logic        READ_REQ;
    logic [7:0]  READ_AGE;
    logic        READ_VALID;
    entry_t      READ_DATA;
    logic [7:0]  WRITE_PTR;
    logic [7:0]  ENTRY_COUNT;
    logic        BUSY;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n = 0;
    logic [15:0] seed = 16'h005E;
    entry_t      exp_q[$];
    logic [47:0] stamp = 48'h0;
    logic [7:0]  p_in = 8'h00;
    logic [7:0]  p_rel = 8'h00;
    logic [31:0] p_alm = 32'h0;
    logic        t_pend = 1'b0;
    logic [20:0] t_data = 21'h0;

    event_recorder dut (.CLK(CLK), .RESET(RESET), .PASS_DONE(PASS_DONE),
        .BINARY_IN(BINARY_IN), .RELAY_STATE(RELAY_STATE),
        .ALARM_STATE(ALARM_STATE), .TRIP_VALID(TRIP_VALID),
        .TRIP_ELEMENT(TRIP_ELEMENT), .TRIP_VALUE(TRIP_VALUE),
        .TIME_LOAD(TIME_LOAD), .TIME_VALUE(TIME_VALUE),
        .READ_REQ(READ_REQ), .READ_AGE(READ_AGE), .READ_VALID(READ_VALID),
        .READ_DATA(READ_DATA), .WRITE_PTR(WRITE_PTR),
        .ENTRY_COUNT(ENTRY_COUNT), .BUSY(BUSY));
    remote_reader host (.clk(CLK), .read_req(READ_REQ),
        .read_age(READ_AGE), .read_valid(READ_VALID),
        .read_data(READ_DATA));

    initial
    begin
        forever #2 CLK = ~CLK;
    end

    function automatic logic [15:0] next_rand();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : next_rand

    function automatic entry_t mk(input event_rec_pkg::kind_e k,
                                  input logic [31:0] d);
        return {k, d, stamp};
    endfunction : mk

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic check_entry(input string w, input entry_t e,
                               input entry_t g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask : check_entry

    task automatic check_byte(input string w, input logic [7:0] e,
                              input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask : check_byte

    // oldest entry drops out of the model once capacity is exceeded
    task automatic add(input entry_t e);
        exp_q.push_back(e);
        if (exp_q.size() > event_rec_pkg::LOG_DEPTH)
            exp_q.pop_front();
        n++;
    endtask : add

    // the logger shows idle for one cycle between two entries, so idle
    // counts only after two quiet samples in a row
    task automatic wait_idle;
        int i;
        int quiet;
        i = 0;
        quiet = 0;
        repeat (2) @(posedge CLK);
        #1;
        while (quiet < 2 && i < 400)
        begin
            quiet = (BUSY === 1'b0) ? quiet + 1 : 0;
            if (quiet < 2)
            begin
                @(posedge CLK);
                #1;
            end
            i++;
        end
        check_byte("BUSY", 8'h00, {7'h0, BUSY});
    endtask : wait_idle

    task automatic run_pass(input logic [7:0] bin, input logic [7:0] rel,
                            input logic [31:0] alm);
        @(posedge CLK);
        BINARY_IN <= bin;
        RELAY_STATE <= rel;
        ALARM_STATE <= alm;
        PASS_DONE <= 1'b1;
        @(posedge CLK);
        PASS_DONE <= 1'b0;
        if (bin !== p_in)
            add(mk(event_rec_pkg::KIND_INPUT, {24'h0, bin}));
        if (rel !== p_rel)
            add(mk(event_rec_pkg::KIND_RELAY, {24'h0, rel}));
        if (t_pend)
            add(mk(event_rec_pkg::KIND_TRIP, {11'h0, t_data}));
        for (int b = 0; b < 32; b++)
            if (alm[b] !== p_alm[b])
                add(mk(event_rec_pkg::KIND_ALARM,
                       {26'h0, alm[b], 5'(b)}));
        p_in = bin;
        p_rel = rel;
        p_alm = alm;
        t_pend = 1'b0;
        wait_idle();
        check_byte("WRITE_PTR", 8'(n % 200), WRITE_PTR);
        check_byte("ENTRY_COUNT", 8'((n > 200) ? 200 : n),
                   ENTRY_COUNT);
    endtask : run_pass

    task automatic verify(input int k);
        entry_t d;
        logic   got;
        for (int a = 0; a < k; a++)
        begin
            host.fetch(8'(a), d, got);
            check_byte("READ_VALID", 8'h01, {7'h0, got});
            check_entry("READ_DATA", exp_q[exp_q.size() - 1 - a],
                        d);
        end
    endtask : verify

    task automatic load_time;
        @(posedge CLK);
        stamp = {next_rand(), next_rand(), next_rand()};
        TIME_LOAD <= 1'b1;
        TIME_VALUE <= stamp;
        @(posedge CLK);
        TIME_LOAD <= 1'b0;
        TIME_VALUE <= ~stamp;
    endtask : load_time

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        #1;
        check_byte("WRITE_PTR", event_rec_pkg::PTR_RESET, WRITE_PTR);
        check_byte("ENTRY_COUNT", event_rec_pkg::COUNT_RESET,
                   ENTRY_COUNT);
        check_byte("READ_VALID", 8'h00, {7'h0, READ_VALID});
        load_time();
        run_pass(8'h00, 8'h00, 32'h0);
        run_pass(8'h5A | 8'(next_rand()), 8'h81 | 8'(next_rand()),
                 32'h0);
        verify(2);
        run_pass(p_in, p_rel, 32'h8000_0003);
        verify(3);
        run_pass(p_in, p_rel, {next_rand(), next_rand()});
        verify(8);
        run_pass(p_in, p_rel, 32'h0);
        verify(4);
        // two trips before logging: the later one is kept
        for (int t = 0; t < 2; t++)
        begin
            @(posedge CLK);
            TRIP_VALID <= 1'b1;
            TRIP_ELEMENT <= 5'(next_rand());
            TRIP_VALUE <= next_rand();
            #1;
            t_data = {TRIP_ELEMENT, TRIP_VALUE};
        end
        @(posedge CLK);
        TRIP_VALID <= 1'b0;
        t_pend = 1'b1;
        wait_idle();
        run_pass(p_in, p_rel, 32'h0);
        verify(1);
        // overfill so that the log wraps and the count saturates
        for (int i = 0; i < 205; i++)
        begin
            if (i == 100)
                load_time();
            run_pass(p_in ^ (8'(next_rand()) | 8'h01), 8'(next_rand()),
                     32'h0);
        end
        verify(200);
        test_done();
    end
endmodule : test_protection_event_recorder
`default_nettype wire
